// ---- design/dsw_descriptor_walker.sv ----
// descriptor schedule walker with apb registers and descriptor memory
//
// Summary of operation
// - when enabled, walk isochronous list, then periodic interrupt, then async list
// - completions grouped per list by and-mask and or-mask into an interrupt
// - a descriptor counts complete when its done flag is set
// - four interrupt sources; latency programmable in whole 125 us microframes
// - each pass walks slots in order, honouring skip marks and final marker
// - active, valid descriptor with clear done flag gets its transaction executed
// - forward link index sits in bits 4 to 0 of the third descriptor word
// - forward link only moves to higher slots, never backward
// - skipped descriptor is ignored, walk moves to next sequential slot
// - forward link of a skipped descriptor is disregarded
// - bytes done count is fifteen bits, at most 32 kB minus one
// - each list holds at most 32 descriptor slots
// - jump flag bit 5 clear increments, set branches through forward link
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module dsw_descriptor_walker (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [12:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             irq,
	output logic                             xact_req,
	output logic [1:0]                       xact_list,
	output logic [4:0]                       xact_slot,
	output logic [dsw_pkg::BYTES_W-1:0]      xact_bytes_req,
	input  wire logic                        xact_done,
	input  wire logic [dsw_pkg::BYTES_W-1:0] xact_bytes_done
);
	import dsw_pkg::*;

	// ==========================================================
	// address decode
	function automatic logic [3:0] addr_group(input logic [12:0] a);
		logic [3:0] g;
		g = G_NONE;
		if (a[1:0] != 2'h0)
			g = G_NONE;
		else if (a[12])
		begin
			if (a[11:4] < 8'd96 && a[3:2] != 2'h3)
				g = G_DESC;
		end
		else if (a == OFF_CTRL)
			g = G_CTRL;
		else if (a == OFF_STATUS)
			g = G_STAT;
		else if (a == OFF_IRQ_STAT)
			g = G_IRQS;
		else if (a == OFF_IRQ_MASK)
			g = G_IRQM;
		else if (a[3:2] == 2'h3)
			g = G_NONE;
		else if (a[12:4] == OFF_SKIP[12:4])
			g = G_SKIP;
		else if (a[12:4] == OFF_FINAL[12:4])
			g = G_FINAL;
		else if (a[12:4] == OFF_DONE[12:4])
			g = G_DONE;
		else if (a[12:4] == OFF_AND[12:4])
			g = G_AND;
		else if (a[12:4] == OFF_OR[12:4])
			g = G_OR;
		return g;
	endfunction : addr_group

	// first enabled list at or above a starting list, with a found flag
	function automatic logic [2:0] first_list(input logic [2:0] en, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NUM_LISTS - 1; i >= 0; i--)
			if (en[i] && i >= int'(from))
				r = {1'b1, 2'(i)};
		return r;
	endfunction : first_list

	// ==========================================================
	// storage
	logic [31:0]   ctrl_q;
	logic [31:0]   irq_stat_q;
	logic [31:0]   irq_mask_q;
	logic [3:0]    pend_q;
	logic [31:0]   skip_q   [NUM_LISTS];
	logic [31:0]   final_q  [NUM_LISTS];
	logic [31:0]   done_q   [NUM_LISTS];
	logic [31:0]   and_q    [NUM_LISTS];
	logic [31:0]   or_q     [NUM_LISTS];
	logic [31:0]   desc_ctrl  [DESC_SLOTS];
	logic [31:0]   desc_state [DESC_SLOTS];
	logic [31:0]   desc_link  [DESC_SLOTS];
	logic [31:0]   prdata_q;
	logic          pready_q;
	logic          pslverr_q;
	logic          irq_q;
	dsw_state_type state_q;
	logic [1:0]    list_q;
	logic [4:0]    slot_q;
	logic          xact_req_q;
	logic [1:0]    xact_list_q;
	logic [4:0]    xact_slot_q;
	logic [BYTES_W-1:0] xact_bytes_q;
	logic [NUM_LISTS-1:0] hit;
	logic [NUM_LISTS-1:0] hit_q;

	// ==========================================================
	// bus and walker combinational terms
	logic [3:0]  grp;
	logic [1:0]  ridx;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rd_mux;
	logic [6:0]  cur_idx;
	logic [6:0]  xact_idx;
	logic [6:0]  bus_idx;
	logic        cur_skip;
	logic        cur_live;
	logic        jump_ok;
	logic        end_of_list;
	logic        advance;
	logic [4:0]  nxt_slot;
	logic [2:0]  en;
	logic [2:0]  nl_start;
	logic [2:0]  nl_after;
	logic        uframe_tick;
	logic        post;
	logic [3:0]  ev;

	assign grp      = addr_group(paddr);
	assign ridx     = paddr[3:2];
	assign bus_idx  = paddr[10:4];
	assign wr_en    = psel & penable & pready_q & pwrite;
	assign rd_en    = psel & penable & pready_q & ~pwrite;
	assign en       = ctrl_q[CTRL_EN_LSB +: NUM_LISTS];
	assign cur_idx  = {list_q, slot_q};
	assign xact_idx = {xact_list_q, xact_slot_q};

	// walk decisions for the current slot
	assign cur_skip = skip_q[list_q][slot_q];
	assign cur_live = desc_state[cur_idx][DESC_ACTIVE_BIT] & desc_ctrl[cur_idx][DESC_VALID_BIT]
		& ~done_q[list_q][slot_q];
	assign jump_ok  = ~cur_skip & desc_link[cur_idx][DESC_JUMP_BIT]
		& (desc_link[cur_idx][4:0] > slot_q);
	assign nxt_slot = jump_ok ? desc_link[cur_idx][4:0] : slot_q + 5'h1;
	assign end_of_list = (final_q[list_q][FINAL_EN_BIT] & (final_q[list_q][4:0] == slot_q))
		| (slot_q == 5'(SLOTS - 1));
	assign advance  = ((state_q == st_check) & ~(~cur_skip & cur_live))
		| ((state_q == st_wait) & xact_done);
	assign nl_start = first_list(en, 3'h0);
	assign nl_after = first_list(en, {1'b0, list_q} + 3'h1);

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign irq            = irq_q;
	assign xact_req       = xact_req_q;
	assign xact_list      = xact_list_q;
	assign xact_slot      = xact_slot_q;
	assign xact_bytes_req = xact_bytes_q;

	// ==========================================================
	// submodules
	dsw_frame_timer u_timer (
		.pclk        (pclk),
		.presetn     (presetn),
		.latency     (ctrl_q[CTRL_LAT_LSB +: LAT_W]),
		.uframe_tick (uframe_tick),
		.post        (post)
	);

	// one and/or combiner per list
	genvar gl;
	generate
		for (gl = 0; gl < NUM_LISTS; gl++)
		begin : g_comb
			dsw_group_combine u_comb (
				.done_map (done_q[gl]),
				.and_mask (and_q[gl]),
				.or_mask  (or_q[gl]),
				.hit      (hit[gl])
			);
		end
	endgenerate

	// ==========================================================
	// apb read mux
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (grp)
			G_CTRL:  rd_mux = ctrl_q;
			G_STAT:  rd_mux = {15'h0000, state_q != st_idle, 6'h00, list_q, 3'h0, slot_q};
			G_IRQS:  rd_mux = irq_stat_q;
			G_IRQM:  rd_mux = irq_mask_q;
			G_SKIP:  rd_mux = skip_q[ridx];
			G_FINAL: rd_mux = final_q[ridx];
			G_DONE:  rd_mux = done_q[ridx];
			G_AND:   rd_mux = and_q[ridx];
			G_OR:    rd_mux = or_q[ridx];
			G_DESC:
			begin
				if (ridx == W_CTRL)
					rd_mux = desc_ctrl[bus_idx];
				else if (ridx == W_STATE)
					rd_mux = desc_state[bus_idx];
				else
					rd_mux = desc_link[bus_idx];
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// apb answer: one setup cycle then a single-cycle access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= psel & ~penable;
			pslverr_q <= psel & ~penable & (grp == G_NONE);
			if (psel & ~penable & ~pwrite)
				prdata_q <= rd_mux;
		end
	end

	// software-written control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q     <= CTRL_RST;
			irq_mask_q <= MASK_RST;
			for (int i = 0; i < NUM_LISTS; i++)
			begin
				skip_q[i]  <= MASK_RST;
				final_q[i] <= FINAL_RST;
				and_q[i]   <= MASK_RST;
				or_q[i]    <= MASK_RST;
			end
		end
		else if (wr_en)
		begin
			if (grp == G_CTRL)
				ctrl_q <= pwdata;
			else if (grp == G_IRQM)
				irq_mask_q <= pwdata;
			else if (grp == G_SKIP)
				skip_q[ridx] <= pwdata;
			else if (grp == G_FINAL)
				final_q[ridx] <= pwdata;
			else if (grp == G_AND)
				and_q[ridx] <= pwdata;
			else if (grp == G_OR)
				or_q[ridx] <= pwdata;
		end
	end

	// completion maps: hardware sets on finish, software writes one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_LISTS; i++)
				done_q[i] <= 32'h0000_0000;
		end
		else
		begin
			for (int i = 0; i < NUM_LISTS; i++)
				done_q[i] <= (done_q[i] & ~((wr_en && grp == G_DONE && ridx == 2'(i)) ? pwdata : 32'h0000_0000))
					| (((state_q == st_wait) && xact_done && xact_list_q == 2'(i))
					? (32'h0000_0001 << xact_slot_q) : 32'h0000_0000);
		end
	end

	// descriptor memory: bus writes, then walker write-back of finished transactions
	always_ff @(posedge pclk)
	begin
		if (wr_en && grp == G_DESC)
		begin
			if (ridx == W_CTRL)
				desc_ctrl[bus_idx] <= pwdata;
			else if (ridx == W_STATE)
				desc_state[bus_idx] <= pwdata;
			else
				desc_link[bus_idx] <= pwdata;
		end
		if (state_q == st_wait && xact_done)
			desc_state[xact_idx] <= {1'b0, desc_state[xact_idx][30:BYTES_W],
				xact_bytes_done};
	end

	// walker: list order, slot walk, transaction issue
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= st_idle;
			list_q       <= 2'h0;
			slot_q       <= 5'h00;
			xact_req_q   <= 1'b0;
			xact_list_q  <= 2'h0;
			xact_slot_q  <= 5'h00;
			xact_bytes_q <= '0;
		end
		else
		begin
			case (state_q)
				st_idle:
				begin
					if (uframe_tick && nl_start[2])
					begin
						list_q  <= nl_start[1:0];
						slot_q  <= 5'h00;
						state_q <= st_check;
					end
				end
				st_check:
				begin
					if (!cur_skip && cur_live)
					begin
						xact_req_q   <= 1'b1;
						xact_list_q  <= list_q;
						xact_slot_q  <= slot_q;
						xact_bytes_q <= desc_ctrl[cur_idx][DESC_REQ_LSB +: BYTES_W];
						state_q      <= st_wait;
					end
				end
				st_wait:
				begin
					if (xact_done)
						xact_req_q <= 1'b0;
				end
				default: state_q <= st_idle;
			endcase
			if (advance)
			begin
				if (!end_of_list)
				begin
					slot_q  <= nxt_slot;
					state_q <= st_check;
				end
				else if (nl_after[2])
				begin
					list_q  <= nl_after[1:0];
					slot_q  <= 5'h00;
					state_q <= st_check;
				end
				else
					state_q <= st_idle;
			end
		end
	end

	// interrupt events: list group rises and microframe start
	assign ev = {uframe_tick, hit & ~hit_q};

	// pending events held until the latency post, status read-clears, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hit_q      <= '0;
			pend_q     <= 4'h0;
			irq_stat_q <= 32'h0000_0000;
			irq_q      <= 1'b0;
		end
		else
		begin
			hit_q      <= hit;
			pend_q     <= post ? 4'h0 : (pend_q | ev);
			irq_stat_q <= ((rd_en && grp == G_IRQS) ? 32'h0000_0000 : irq_stat_q)
				| (post ? {28'h000_0000, pend_q | ev} : 32'h0000_0000);
			irq_q      <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule : dsw_descriptor_walker

// ---- design/dsw_pkg.sv ----
// constants and types shared by the descriptor schedule walker
package dsw_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_LISTS   = 3;
	localparam int SLOTS       = 32;
	localparam int DESC_SLOTS  = 96;
	localparam int BYTES_W     = 15;
	localparam int LAT_W       = 4;

	// ==========================================================
	// register byte offsets
	localparam logic [12:0] OFF_CTRL     = 13'h0000;
	localparam logic [12:0] OFF_STATUS   = 13'h0004;
	localparam logic [12:0] OFF_IRQ_STAT = 13'h0008;
	localparam logic [12:0] OFF_IRQ_MASK = 13'h000c;
	localparam logic [12:0] OFF_SKIP     = 13'h0010;
	localparam logic [12:0] OFF_FINAL    = 13'h0020;
	localparam logic [12:0] OFF_DONE     = 13'h0030;
	localparam logic [12:0] OFF_AND      = 13'h0040;
	localparam logic [12:0] OFF_OR       = 13'h0050;
	localparam logic [12:0] OFF_DESC     = 13'h1000;

	// ==========================================================
	// decoded address groups
	localparam logic [3:0] G_CTRL  = 4'h0;
	localparam logic [3:0] G_STAT  = 4'h1;
	localparam logic [3:0] G_IRQS  = 4'h2;
	localparam logic [3:0] G_IRQM  = 4'h3;
	localparam logic [3:0] G_SKIP  = 4'h4;
	localparam logic [3:0] G_FINAL = 4'h5;
	localparam logic [3:0] G_DONE  = 4'h6;
	localparam logic [3:0] G_AND   = 4'h7;
	localparam logic [3:0] G_OR    = 4'h8;
	localparam logic [3:0] G_DESC  = 4'h9;
	localparam logic [3:0] G_NONE  = 4'hf;

	// ==========================================================
	// field positions
	localparam int CTRL_EN_LSB     = 0;
	localparam int CTRL_LAT_LSB    = 8;
	localparam int STATUS_SLOT_LSB = 0;
	localparam int STATUS_LIST_LSB = 8;
	localparam int STATUS_BUSY_BIT = 16;
	localparam int FINAL_EN_BIT    = 8;
	localparam int DESC_VALID_BIT  = 0;
	localparam int DESC_REQ_LSB    = 3;
	localparam int DESC_ACTIVE_BIT = 31;
	localparam int DESC_JUMP_BIT   = 5;
	localparam int IRQ_SOF_BIT     = 3;
	localparam logic [1:0] W_CTRL  = 2'h0;
	localparam logic [1:0] W_STATE = 2'h1;
	localparam logic [1:0] W_LINK  = 2'h2;

	// ==========================================================
	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] MASK_RST  = 32'h0000_0000;
	localparam logic [31:0] FINAL_RST = 32'h0000_0000;

	// ==========================================================
	// timing
	localparam int UFRAME_NS     = 125000;
	localparam int CLK_NS        = 100;
	localparam int UFRAME_CYCLES = UFRAME_NS / CLK_NS;
	localparam int UFRAME_CNT_W  = 11;

	typedef enum logic [1:0] {st_idle, st_check, st_wait} dsw_state_type;

endpackage : dsw_pkg

// ---- design/dsw_group_combine.sv ----
// and/or grouping of one list's completion map into a single hit
`timescale 1ns/10ps
module dsw_group_combine (
	input  wire logic [31:0] done_map,
	input  wire logic [31:0] and_mask,
	input  wire logic [31:0] or_mask,
	output logic             hit
);
	import dsw_pkg::*;

	// any or-bit done, or every and-bit done when an and-group exists
	always_comb
	begin
		hit = (|(done_map & or_mask)) |
		      ((|and_mask) & ((done_map & and_mask) == and_mask));
	end

endmodule : dsw_group_combine

// ---- design/dsw_frame_timer.sv ----
// microframe tick and interrupt latency post generator
`timescale 1ns/10ps
module dsw_frame_timer (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [3:0]       latency,
	output logic                  uframe_tick,
	output logic                  post
);
	import dsw_pkg::*;

	localparam logic [UFRAME_CNT_W-1:0] CNT_MAX = UFRAME_CNT_W'(UFRAME_CYCLES - 1);

	logic [UFRAME_CNT_W-1:0] cnt_q;
	logic [LAT_W-1:0]        lat_q;
	logic                    lat_full;

	assign uframe_tick = (cnt_q == CNT_MAX);
	assign lat_full    = ((lat_q + 4'h1) >= latency);
	// zero latency posts at once, else every latency-th microframe
	assign post        = (latency == 4'h0) | (uframe_tick & lat_full);

	// microframe cycle counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (uframe_tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// microframes elapsed since the last post
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lat_q <= '0;
		else if (uframe_tick)
			lat_q <= lat_full ? 4'h0 : lat_q + 4'h1;
	end

endmodule : dsw_frame_timer

// ---- test/dsw_walker_props.sv ----
// assertions on the walker's top-level ports
`timescale 1ns/10ps
module dsw_walker_props (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [12:0]                 paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        irq,
	input wire logic                        xact_req,
	input wire logic [1:0]                  xact_list,
	input wire logic [4:0]                  xact_slot,
	input wire logic [dsw_pkg::BYTES_W-1:0] xact_bytes_req,
	input wire logic                        xact_done,
	input wire logic [dsw_pkg::BYTES_W-1:0] xact_bytes_done
);
	import dsw_pkg::*;
	// =========
	// shadows of what software wrote
	logic [31:0] ctrl_q;
	logic [3:0]  mask_q;
	logic [31:0] skip_q [3];
	logic [8:0]  fin_q [3];
	logic        wr_hit;
	logic        acc;
	assign acc = psel && penable && pready;
	assign wr_hit = acc && pwrite;
	// track control, mask, skip and final writes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			mask_q <= MASK_RST[3:0];
			skip_q <= '{default: '0};
			fin_q <= '{default: '0};
		end
		else if (wr_hit)
		begin
			if (paddr == OFF_CTRL)
				ctrl_q <= pwdata;
			if (paddr == OFF_IRQ_MASK)
				mask_q <= pwdata[3:0];
			if (paddr[12:4] == 9'h001 && paddr[3:2] != 2'h3)
				skip_q[paddr[3:2]] <= pwdata;
			if (paddr[12:4] == 9'h002 && paddr[3:2] != 2'h3)
				fin_q[paddr[3:2]] <= pwdata[8:0];
		end
	// =========
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	req_hold_a: assert property (
		xact_req && !xact_done |=> xact_req && $stable({xact_list, xact_slot, xact_bytes_req}))
		else $error("transaction request dropped or changed early");
	req_drop_a: assert property (
		xact_req && xact_done |=> !xact_req)
		else $error("transaction request held after completion");
	enabled_list_a: assert property (
		$rose(xact_req) |-> ctrl_q[xact_list])
		else $error("transaction on a disabled list");
	skip_honour_a: assert property (
		$rose(xact_req) |-> !skip_q[xact_list][xact_slot])
		else $error("transaction on a skipped slot");
	final_bound_a: assert property (
		$rose(xact_req) && fin_q[xact_list][8] |-> xact_slot <= fin_q[xact_list][4:0])
		else $error("transaction past the final slot");
	ctrl_read_a: assert property (
		acc && !pwrite && paddr == OFF_CTRL |->
		(prdata & 32'h0000_0f07) == (ctrl_q & 32'h0000_0f07))
		else $error("control readback differs");
	bad_addr_a: assert property (
		acc && paddr >= 13'h1600 |-> pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("access beyond last slot accepted");
	irq_mask_a: assert property (
		(mask_q == 4'h0) [*2] |-> !irq)
		else $error("interrupt while fully masked");
	cover property ($rose(xact_req) && xact_list == 2'h2);
	cover property (irq ##1 !irq);
	cover property (acc && pslverr);
endmodule : dsw_walker_props

bind dsw_descriptor_walker dsw_walker_props dsw_walker_props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .xact_req(xact_req),
	.xact_list(xact_list), .xact_slot(xact_slot), .xact_bytes_req(xact_bytes_req),
	.xact_done(xact_done), .xact_bytes_done(xact_bytes_done));

// ---- test/dsw_xact_partner.sv ----
// transaction executor model answering the walker's requests
`timescale 1ns/10ps
module dsw_xact_partner (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        slow,
	input  wire logic                        xact_req,
	input  wire logic [dsw_pkg::BYTES_W-1:0] xact_bytes_req,
	output logic                             xact_done,
	output logic [dsw_pkg::BYTES_W-1:0]      xact_bytes_done
);
	import dsw_pkg::*;
	logic [2:0] wait_q;
	// wait zero or five cycles, then complete for one cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wait_q <= 3'h0;
			xact_done <= 1'b0;
		end
		else if (xact_done)
		begin
			wait_q <= 3'h0;
			xact_done <= 1'b0;
		end
		else if (xact_req)
		begin
			wait_q <= wait_q + 3'h1;
			xact_done <= (wait_q == (slow ? 3'h5 : 3'h0));
		end
	// full count while done, the inverted request count otherwise
	assign xact_bytes_done = xact_done ? xact_bytes_req : ~xact_bytes_req;
endmodule : dsw_xact_partner

// ---- test/dsw_descriptor_walker_test.sv ----
// self-checking bench for the descriptor schedule walker
`timescale 1ns/10ps
module dsw_descriptor_walker_test;
	import dsw_pkg::*;
	typedef struct packed {
		logic [1:0]  l;
		logic [4:0]  s;
		logic [14:0] b;
		logic        act;
		logic [5:0]  lnk;
		logic        ex;
	} dsw_row_type;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        xact_req, xact_done, slow, er;
	logic [12:0] paddr, a;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  xact_list;
	logic [4:0]  xact_slot;
	logic [14:0] xact_bytes_req, xact_bytes_done;
	logic [21:0] seen [$];
	int          n_fail, n_tests, j;
	// descriptors and whether each should be executed
	dsw_row_type rows [10] = '{
		'{2'h0, 5'h00, 15'h0010, 1'b1, 6'h00, 1'b1},
		'{2'h0, 5'h01, 15'h0011, 1'b1, 6'h25, 1'b0},
		'{2'h0, 5'h02, 15'h0012, 1'b1, 6'h27, 1'b1},
		'{2'h0, 5'h05, 15'h0013, 1'b1, 6'h00, 1'b0},
		'{2'h0, 5'h07, 15'h0014, 1'b1, 6'h20, 1'b1},
		'{2'h0, 5'h08, 15'h0015, 1'b0, 6'h00, 1'b0},
		'{2'h0, 5'h0a, 15'h7fff, 1'b1, 6'h00, 1'b1},
		'{2'h0, 5'h0b, 15'h0016, 1'b1, 6'h00, 1'b0},
		'{2'h1, 5'h03, 15'h0020, 1'b1, 6'h00, 1'b1},
		'{2'h2, 5'h1f, 15'h0030, 1'b1, 6'h00, 1'b1}};
	dsw_descriptor_walker dsw_descriptor_walker_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .xact_req(xact_req),
		.xact_list(xact_list), .xact_slot(xact_slot), .xact_bytes_req(xact_bytes_req),
		.xact_done(xact_done), .xact_bytes_done(xact_bytes_done));
	dsw_xact_partner dsw_xact_partner_i (.pclk(pclk), .presetn(presetn), .slow(slow),
		.xact_req(xact_req), .xact_bytes_req(xact_bytes_req), .xact_done(xact_done),
		.xact_bytes_done(xact_bytes_done));
	// =========
	// clock, log of completed transactions, watchdog
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (xact_req === 1'b1 && xact_done === 1'b1)
		begin
			seen.push_back({xact_list, xact_slot, xact_bytes_req});
			slow <= ~slow;
		end
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		$display("FAIL watchdog expected finish seen hang");
		stop_test();
	end
	// =========
	// tasks
	task automatic apb(input logic w, input logic [12:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// =========
	// main sequence
	initial
	begin
		n_fail = 0;
		n_tests = 0;
		{psel, penable, pwrite, slow, presetn} = 5'h00;
		paddr = 13'h0000;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge pclk);
		chk("reset outputs", 32'h0000_0000, {28'h000_0000, xact_req, irq, pready, pslverr});
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk("ctrl reset", CTRL_RST, rd);
		apb(1'b0, OFF_IRQ_MASK, 32'h0000_0000);
		chk("mask reset", MASK_RST, rd);
		for (int i = 0; i < 288; i++)
			apb(1'b1, OFF_DESC + 13'(i / 3 * 16 + i % 3 * 4), 32'h0000_0000);
		for (int i = 0; i < 15; i++)
			apb(1'b1, 13'(16 + i / 3 * 16 + i % 3 * 4), (i / 3 == 2) ? '1 : '0);
		foreach (rows[k])
		begin
			a = OFF_DESC + 13'((rows[k].l * 32 + rows[k].s) * 16);
			apb(1'b1, a, {14'h0000, rows[k].b, 3'h1});
			apb(1'b1, a + 13'h0004, {rows[k].act, 31'h0000_0000});
			apb(1'b1, a + 13'h0008, {26'h000_0000, rows[k].lnk});
		end
		apb(1'b1, OFF_SKIP, 32'h0000_0002);
		apb(1'b1, OFF_FINAL, 32'h0000_010a);
		apb(1'b1, OFF_OR, 32'h0000_0001);
		apb(1'b1, OFF_AND + 13'h0004, 32'h0000_0008);
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
		apb(1'b1, OFF_CTRL, 32'h0000_0007);
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk("ctrl readback", 32'h0000_0007, rd);
		for (int t = 0; t < 4000 && seen.size() < 6; t++)
			@(posedge pclk);
		repeat (1400) @(posedge pclk);
		chk("transaction count", 32'h0000_0006, 32'(seen.size()));
		j = 0;
		foreach (rows[k])
			if (rows[k].ex)
			begin
				chk("transaction", {10'h000, rows[k][29:8]}, {10'h000, seen[j]});
				j++;
			end
		apb(1'b0, OFF_DONE, 32'h0000_0000);
		chk("iso done map", 32'h0000_0485, rd);
		apb(1'b0, OFF_DESC + 13'h00a4, 32'h0000_0000);
		chk("bytes done", 32'h0000_7fff, rd);
		chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
		chk("irq status", 32'h0000_000b, rd);
		apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
		chk("status cleared", 32'h0000_0000, rd);
		apb(1'b0, 13'h001c, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0001, {rd[30:0], er});
		apb(1'b1, 13'h1600, 32'h0000_0000);
		chk("beyond last slot", 32'h0000_0001, {31'h0000_0000, er});
		// latency of two: start of frame posts on every second microframe only
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0008);
		apb(1'b1, OFF_CTRL, 32'h0000_0207);
		for (int t = 0; t < 6000 && irq !== 1'b1; t++)
			@(posedge pclk);
		apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
		chk("sof posted", 32'h0000_0008, rd);
		repeat (2) @(posedge pclk);
		// j counts edges since irq was first seen high
		j = 5;
		while (irq !== 1'b1 && j < 6000)
		begin
			@(posedge pclk);
			j++;
		end
		chk("sof latency", 32'(2 * UFRAME_CYCLES), 32'(j));
		stop_test();
	end
endmodule : dsw_descriptor_walker_test
